// ===== hdl/bus_cycle_if.sv
// one flash bus cycle request between the sequencer and the pin engine
`timescale 1ns/1ps
interface bus_cycle_if;
  logic        req;
  logic        wr;
  logic        hv;
  logic [16:0] addr;
  logic [7:0]  wdata;
  logic        done;
  logic [7:0]  rdata;
  modport seq  (output req, wr, hv, addr, wdata, input done, rdata);
  modport pins (input req, wr, hv, addr, wdata, output done, rdata);
endinterface : bus_cycle_if

// ===== hdl/flash_cmd_host.sv
// host controller that sequences flash commands onto the bus pins
`timescale 1ns/1ps
module flash_cmd_host (
  input  wire logic        REF_CLK_IN,
  input  wire logic        SRST_IN,
  input  wire logic        CMD_VALID_IN,
  input  wire logic [2:0]  CMD_OP_IN,
  input  wire logic [16:0] CMD_ADDR_IN,
  input  wire logic [7:0]  CMD_DATA_IN,
  output logic             CMD_READY_OUT,
  output logic             RESP_VALID_OUT,
  output logic [7:0]       RESP_DATA_OUT,
  output logic             ID_MODE_OUT,
  output logic             FLASH_CE_N_OUT,
  output logic             FLASH_OE_N_OUT,
  output logic             FLASH_WE_N_OUT,
  output logic [16:0]      FLASH_ADDR_OUT,
  input  wire logic [7:0]  DATA_PINS_IN,
  output logic [7:0]       DATA_PINS_OUT,
  output logic             DATA_PINS_OE_OUT,
  output logic             ID_VOLTAGE_EN_OUT
);
  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} seq_t;

  bus_cycle_if cyc ();

  seq_t                 state_reg, state_next;
  flash_host_pkg::op_t  op_reg, op_next;
  logic [16:0]          addr_reg, addr_next;
  logic [7:0]           data_reg, data_next;
  logic [2:0]           step_reg, step_next;
  logic                 ready_reg, ready_next, rvalid_reg, rvalid_next;
  logic [7:0]           rdata_reg, rdata_next;
  logic                 idm_reg, idm_next;
  logic                 req_reg, req_next;

  // last step index of each operation
  function automatic logic [2:0] last_step(flash_host_pkg::op_t op);
    unique case (op)
      flash_host_pkg::OP_READ, flash_host_pkg::OP_ID_READ: return 3'h0;
      flash_host_pkg::OP_PROGRAM: return flash_host_pkg::LAST_STEP_PROG;
      flash_host_pkg::OP_CHIP_ERASE,
      flash_host_pkg::OP_SECTOR_ERASE: return flash_host_pkg::LAST_STEP_ERASE;
      default: return flash_host_pkg::LAST_STEP_SHORT;
    endcase
  endfunction : last_step

  function automatic logic is_read(flash_host_pkg::op_t op);
    return (op == flash_host_pkg::OP_READ) || (op == flash_host_pkg::OP_ID_READ);
  endfunction : is_read

  // address for a step; bit 16 of unlock cycles stays low since the flash ignores it
  function automatic logic [16:0] step_addr(flash_host_pkg::op_t op, logic [2:0] s,
                                            logic [16:0] ua);
    if (op == flash_host_pkg::OP_READ) return ua;
    if (op == flash_host_pkg::OP_ID_READ)
      return {ua[16:flash_host_pkg::SECT_LSB], 12'h000, ua[1:0]};
    unique case (s)
      3'h1, 3'h4: return flash_host_pkg::UNLOCK_ADDR2;
      3'h3: return (op == flash_host_pkg::OP_PROGRAM) ? ua
                   : flash_host_pkg::UNLOCK_ADDR1;
      3'h5: return (op == flash_host_pkg::OP_SECTOR_ERASE) ? ua
                   : flash_host_pkg::UNLOCK_ADDR1;
      default: return flash_host_pkg::UNLOCK_ADDR1;
    endcase
  endfunction : step_addr

  // data for a step of a command sequence
  function automatic logic [7:0] step_data(flash_host_pkg::op_t op, logic [2:0] s,
                                           logic [7:0] ud);
    unique case (s)
      3'h0: return flash_host_pkg::UNLOCK_DATA1;
      3'h1, 3'h4: return flash_host_pkg::UNLOCK_DATA2;
      3'h2: unique case (op)
        flash_host_pkg::OP_RESET:    return flash_host_pkg::CODE_RESET;
        flash_host_pkg::OP_ID_ENTER: return flash_host_pkg::CODE_ID;
        flash_host_pkg::OP_PROGRAM:  return flash_host_pkg::CODE_PROGRAM;
        default:                     return flash_host_pkg::CODE_ERASE;
      endcase
      3'h3: return (op == flash_host_pkg::OP_PROGRAM) ? ud : flash_host_pkg::UNLOCK_DATA1;
      default: return (op == flash_host_pkg::OP_CHIP_ERASE) ? flash_host_pkg::CODE_CHIP
                      : flash_host_pkg::CODE_SECTOR;
    endcase
  endfunction : step_data

  // sequencer: one bus cycle per step, the engine reports each cycle done
  always_comb begin
    state_next  = state_reg;
    op_next     = op_reg;
    addr_next   = addr_reg;
    data_next   = data_reg;
    step_next   = step_reg;
    ready_next  = ready_reg;
    rvalid_next = 1'b0;
    rdata_next  = rdata_reg;
    idm_next    = idm_reg;
    req_next    = 1'b0;
    unique case (state_reg)
      S_IDLE: if (CMD_VALID_IN && ready_reg) begin
        op_next    = flash_host_pkg::op_t'(CMD_OP_IN);
        addr_next  = CMD_ADDR_IN;
        data_next  = CMD_DATA_IN;
        step_next  = 3'h0;
        ready_next = 1'b0;
        state_next = S_ISSUE;
      end
      S_ISSUE: begin
        req_next   = 1'b1;
        state_next = S_WAIT;
      end
      S_WAIT: if (cyc.done) begin
        if (step_reg == last_step(op_reg)) begin
          if (is_read(op_reg)) begin
            rvalid_next = 1'b1;
            rdata_next  = cyc.rdata;
          end
          if (op_reg == flash_host_pkg::OP_ID_ENTER) idm_next = 1'b1;
          if (op_reg == flash_host_pkg::OP_RESET)    idm_next = 1'b0;
          ready_next = 1'b1;
          state_next = S_IDLE;
        end else begin
          step_next  = step_reg + 3'h1;
          state_next = S_ISSUE;
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  // registers; power-up state assumes the flash sits in read mode
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      state_reg  <= S_IDLE;
      op_reg     <= flash_host_pkg::OP_READ;
      addr_reg   <= 17'h00000;
      data_reg   <= 8'h00;
      step_reg   <= 3'h0;
      ready_reg  <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg  <= 8'h00;
      idm_reg    <= 1'b0;
      req_reg    <= 1'b0;
    end else begin
      state_reg  <= state_next;
      op_reg     <= op_next;
      addr_reg   <= addr_next;
      data_reg   <= data_next;
      step_reg   <= step_next;
      ready_reg  <= ready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rdata_next;
      idm_reg    <= idm_next;
      req_reg    <= req_next;
    end
  end

  // request fields are stable while the engine works, so they can be decoded live
  assign cyc.req   = req_reg;
  assign cyc.wr    = ~is_read(op_reg);
  assign cyc.hv    = (op_reg == flash_host_pkg::OP_ID_READ) & ~idm_reg;
  assign cyc.addr  = step_addr(op_reg, step_reg, addr_reg);
  assign cyc.wdata = step_data(op_reg, step_reg, data_reg);

  flash_pin_engine engine (
    .clk_in           (REF_CLK_IN),
    .srst_in          (SRST_IN),
    .cyc              (cyc.pins),
    .data_pins_in     (DATA_PINS_IN),
    .ce_n_out         (FLASH_CE_N_OUT),
    .oe_n_out         (FLASH_OE_N_OUT),
    .we_n_out         (FLASH_WE_N_OUT),
    .addr_out         (FLASH_ADDR_OUT),
    .data_pins_out    (DATA_PINS_OUT),
    .data_pins_oe_out (DATA_PINS_OE_OUT),
    .id_voltage_out   (ID_VOLTAGE_EN_OUT)
  );

  assign CMD_READY_OUT  = ready_reg;
  assign RESP_VALID_OUT = rvalid_reg;
  assign RESP_DATA_OUT  = rdata_reg;
  assign ID_MODE_OUT    = idm_reg;

  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (SRST_IN);

  unlock_first_a: assert property (req_reg && cyc.wr && step_reg == 3'h0
      |-> cyc.addr == 17'h05555 && cyc.wdata == 8'hAA)
    else $error("first unlock write wrong");
  unlock_second_a: assert property (req_reg && cyc.wr && step_reg == 3'h1
      |-> cyc.addr == 17'h02AAA && cyc.wdata == 8'h55)
    else $error("second unlock write wrong");
  id_enter_a: assert property (state_reg == S_WAIT && cyc.done && step_reg == 3'h2
      && op_reg == flash_host_pkg::OP_ID_ENTER |=> idm_reg && ready_reg)
    else $error("identification mode not recorded after entry");
  id_exit_a: assert property ($fell(idm_reg)
      |-> $past(op_reg) == flash_host_pkg::OP_RESET)
    else $error("identification mode left without read/reset");
  prog_target_a: assert property (req_reg && op_reg == flash_host_pkg::OP_PROGRAM
      && step_reg == 3'h3 |-> cyc.addr == addr_reg && cyc.wdata == data_reg)
    else $error("program cycle does not carry target address and value");
  erase_last_a: assert property (req_reg && step_reg == 3'h5 |-> cyc.wdata ==
      ((op_reg == flash_host_pkg::OP_CHIP_ERASE) ? 8'h10 : 8'h30))
    else $error("final erase code wrong");
  read_resp_a: assert property (state_reg == S_ISSUE && is_read(op_reg)
      |-> ##[20:30] rvalid_reg)
    else $error("read answer not returned in time");
  cover_prog_c: cover property (state_reg == S_WAIT && cyc.done && step_reg == 3'h3);
  cover_erase_c: cover property (req_reg && step_reg == 3'h5);
  cover_id_c: cover property ($rose(idm_reg));
endmodule : flash_cmd_host

// ===== hdl/flash_host_pkg.sv
// constants, opcodes and timing for the parallel flash command host
package flash_host_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 5;
  // bus timing, least figures in ns, converted to cycles by rounding up
  localparam int CLK_PERIOD_NS  = 8;
  localparam int ADDR_SETUP_NS  = 16;
  localparam int WE_PULSE_NS    = 45;
  localparam int READ_ACCESS_NS = 120;
  localparam int DATA_HOLD_NS   = 8;
  localparam int ADDR_SETUP_CYC  = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_PULSE_CYC    = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_HOLD_CYC   = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // command cycle addresses and data
  localparam logic [16:0] UNLOCK_ADDR1 = 17'h05555;
  localparam logic [16:0] UNLOCK_ADDR2 = 17'h02AAA;
  localparam logic [7:0]  UNLOCK_DATA1 = 8'hAA;
  localparam logic [7:0]  UNLOCK_DATA2 = 8'h55;
  localparam logic [7:0]  CODE_RESET   = 8'hF0;
  localparam logic [7:0]  CODE_ID      = 8'h90;
  localparam logic [7:0]  CODE_PROGRAM = 8'hA0;
  localparam logic [7:0]  CODE_ERASE   = 8'h80;
  localparam logic [7:0]  CODE_CHIP    = 8'h10;
  localparam logic [7:0]  CODE_SECTOR  = 8'h30;
  // identification reads keep only sector bits and the two low bits
  localparam int SECT_LSB = 14;
  localparam logic [2:0] LAST_STEP_SHORT = 3'h2;
  localparam logic [2:0] LAST_STEP_PROG  = 3'h3;
  localparam logic [2:0] LAST_STEP_ERASE = 3'h5;
  typedef enum logic [2:0] {
    OP_READ, OP_RESET, OP_ID_ENTER, OP_PROGRAM, OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_ID_READ
  } op_t;
endpackage : flash_host_pkg

// ===== hdl/flash_pin_engine.sv
// drives one read or write cycle on the flash pins with fixed timing
`timescale 1ns/1ps
module flash_pin_engine (
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  bus_cycle_if.pins        cyc,
  input  wire logic [7:0]  data_pins_in,
  output logic             ce_n_out,
  output logic             oe_n_out,
  output logic             we_n_out,
  output logic [16:0]      addr_out,
  output logic [7:0]       data_pins_out,
  output logic             data_pins_oe_out,
  output logic             id_voltage_out
);
  localparam int CNT_W = flash_host_pkg::CNT_W;
  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} eng_t;
  eng_t        state_reg, state_next;
  logic [4:0]  cnt_reg, cnt_next;
  logic        wr_reg, wr_next;
  logic        ce_n_reg, ce_n_next, oe_n_reg, oe_n_next, we_n_reg, we_n_next;
  logic [16:0] addr_reg, addr_next;
  logic [7:0]  dout_reg, dout_next, rdata_reg, rdata_next;
  logic        doe_reg, doe_next, hv_reg, hv_next, done_reg, done_next;

  // next values of the cycle; strobes rise together so data latches on that edge
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    wr_next    = wr_reg;
    ce_n_next  = ce_n_reg;
    oe_n_next  = oe_n_reg;
    we_n_next  = we_n_reg;
    addr_next  = addr_reg;
    dout_next  = dout_reg;
    doe_next   = doe_reg;
    hv_next    = hv_reg;
    rdata_next = rdata_reg;
    done_next  = 1'b0;
    unique case (state_reg)
      E_IDLE: if (cyc.req) begin
        wr_next    = cyc.wr;
        addr_next  = cyc.addr;
        dout_next  = cyc.wdata;
        doe_next   = cyc.wr;               // OE stays high, so no contention
        hv_next    = cyc.hv & ~cyc.wr;
        cnt_next   = CNT_W'(flash_host_pkg::ADDR_SETUP_CYC - 1);
        state_next = E_SETUP;
      end
      E_SETUP: if (cnt_reg == 5'h00) begin
        ce_n_next  = 1'b0;
        we_n_next  = ~wr_reg;
        oe_n_next  = wr_reg;
        cnt_next   = wr_reg ? CNT_W'(flash_host_pkg::WE_PULSE_CYC - 1)
                            : CNT_W'(flash_host_pkg::READ_ACCESS_CYC - 1);
        state_next = E_STROBE;
      end else begin
        cnt_next = cnt_reg - 5'h01;
      end
      E_STROBE: if (cnt_reg == 5'h00) begin
        if (!wr_reg) rdata_next = data_pins_in;
        ce_n_next  = 1'b1;
        we_n_next  = 1'b1;
        oe_n_next  = 1'b1;
        cnt_next   = CNT_W'(flash_host_pkg::DATA_HOLD_CYC - 1);
        state_next = E_HOLD;
      end else begin
        cnt_next = cnt_reg - 5'h01;
      end
      E_HOLD: if (cnt_reg == 5'h00) begin
        doe_next   = 1'b0;
        hv_next    = 1'b0;
        done_next  = 1'b1;
        state_next = E_IDLE;
      end else begin
        cnt_next = cnt_reg - 5'h01;
      end
    endcase
  end

  // registers; pins park deselected after reset
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_reg <= E_IDLE;
      cnt_reg   <= 5'h00;
      wr_reg    <= 1'b0;
      ce_n_reg  <= 1'b1;
      oe_n_reg  <= 1'b1;
      we_n_reg  <= 1'b1;
      addr_reg  <= 17'h00000;
      dout_reg  <= 8'h00;
      doe_reg   <= 1'b0;
      hv_reg    <= 1'b0;
      rdata_reg <= 8'h00;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      wr_reg    <= wr_next;
      ce_n_reg  <= ce_n_next;
      oe_n_reg  <= oe_n_next;
      we_n_reg  <= we_n_next;
      addr_reg  <= addr_next;
      dout_reg  <= dout_next;
      doe_reg   <= doe_next;
      hv_reg    <= hv_next;
      rdata_reg <= rdata_next;
      done_reg  <= done_next;
    end
  end

  assign ce_n_out         = ce_n_reg;
  assign oe_n_out         = oe_n_reg;
  assign we_n_out         = we_n_reg;
  assign addr_out         = addr_reg;
  assign data_pins_out    = dout_reg;
  assign data_pins_oe_out = doe_reg;
  assign id_voltage_out   = hv_reg;
  assign cyc.done         = done_reg;
  assign cyc.rdata        = rdata_reg;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  write_ctrl_a: assert property (!we_n_reg |-> !ce_n_reg && oe_n_reg)
    else $error("write strobe low without chip select low and gate high");
  we_pulse_a: assert property ($fell(we_n_reg) |-> (!we_n_reg && doe_reg)[*6])
    else $error("write strobe pulse shorter than six cycles or data not driven");
  no_contention_a: assert property (doe_reg |-> oe_n_reg)
    else $error("host drives data while output gate is low");
  read_gate_a: assert property ($fell(oe_n_reg) |-> !ce_n_reg ##15 oe_n_reg)
    else $error("read gate not held for full access time");
  id_voltage_a: assert property (hv_reg |-> we_n_reg && !doe_reg)
    else $error("identification voltage during a write");
  id_addr_a: assert property (hv_reg |-> addr_reg[13:2] == 12'h000)
    else $error("identification read with extra address bits set");
  cover_hv_read_c: cover property (hv_reg && !oe_n_reg);
endmodule : flash_pin_engine

// ===== verif/flash_dev_model.sv
// behavioural model of the parallel flash as seen on its bus pins
`timescale 1ns/1ps
module flash_dev_model #(
  parameter logic [7:0] MAKER_CODE = 8'h07, // arbitrary value, odd parity
  parameter logic [7:0] PART_CODE  = 8'h0B, // arbitrary value, odd parity
  parameter logic [7:0] PROT_MAP   = 8'h24  // one bit per sector, high = protected
) (
  input  wire logic        ce_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic [16:0] addr_in,
  input  wire logic [7:0]  dq_in,
  input  wire logic        host_oe_in,
  input  wire logic        hv_in,
  output logic [7:0]       dq_out,
  output logic             dq_oe_out,
  output logic             clash_out
);
  logic [7:0]  mem [0:131071];
  logic [16:0] lat_addr;
  logic [14:0] lo;
  logic [7:0]  val;
  logic [2:0]  step;
  logic        id_mode;
  wire         wr_act = !ce_n_in && !we_n_in && oe_n_in;
  wire         rd_act = !ce_n_in && !oe_n_in;
  // erased array, read mode at power-up
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    lat_addr = 17'h00000; // strobes leaving x at reset must not match an unlock step
    step = 3'h0;
    id_mode = 1'b0;
    clash_out = 1'b0;
  end
  // address on the later falling strobe, data on the earlier rising one
  always @(posedge wr_act) lat_addr = addr_in;
  always @(negedge wr_act) begin
    lo = lat_addr[14:0];
    case (step)
      3'h0, 3'h4: step = (lo == 15'h5555 && dq_in == 8'hAA) ? step + 3'h1 : 3'h0;
      3'h1, 3'h5: step = (lo == 15'h2AAA && dq_in == 8'h55) ? step + 3'h1 : 3'h0;
      3'h2: begin
        step = 3'h0;
        if (lo == 15'h5555 && dq_in == 8'hA0) step = 3'h3;
        else if (lo == 15'h5555 && dq_in == 8'h80) step = 3'h4;
        else id_mode = (lo == 15'h5555 && dq_in == 8'h90);
      end
      3'h3: begin
        if (!PROT_MAP[lat_addr[16:14]]) mem[lat_addr] = mem[lat_addr] & dq_in;
        step = 3'h0;
      end
      default: begin
        if (lo == 15'h5555 && dq_in == 8'h10) begin
          foreach (mem[i]) if (!PROT_MAP[i[16:14]]) mem[i] = 8'hFF;
        end else if (dq_in == 8'h30 && !PROT_MAP[lat_addr[16:14]]) begin
          for (int i = 0; i < 16384; i++) mem[{lat_addr[16:14], i[13:0]}] = 8'hFF;
        end else id_mode = 1'b0;
        step = 3'h0;
      end
    endcase
    // a broken sequence drops back to read mode
    if (step == 3'h0) id_mode = id_mode && lo == 15'h5555 && dq_in == 8'h90;
  end
  // read data; a released bus shows the inverse so stale values never match
  always_comb begin
    if (hv_in || id_mode) begin
      case (addr_in[1:0])
        2'h0: val = MAKER_CODE;
        2'h1: val = PART_CODE;
        2'h2: val = {7'h00, PROT_MAP[addr_in[16:14]]};
        default: val = 8'h00;
      endcase
    end else val = mem[addr_in];
    dq_oe_out = rd_act;
    dq_out = rd_act ? val : ~val;
  end
  // both parties driving the data pins at once, or a write with gate low
  always @(posedge host_oe_in or posedge rd_act or negedge we_n_in)
    if ((host_oe_in && rd_act) || (!we_n_in && !ce_n_in && !oe_n_in)) clash_out = 1'b1;
endmodule : flash_dev_model

// ===== verif/tb_top.sv
// self-checking bench for the flash command host against the flash model
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] PROT  = 8'h24;
  localparam logic [7:0] MAKER = 8'h07; // arbitrary value, odd parity
  localparam logic [7:0] PART  = 8'h0B; // arbitrary value, odd parity
  logic        clk;
  logic        rst;
  logic        cmd_valid;
  logic [2:0]  cmd_op;
  logic [16:0] cmd_addr;
  logic [7:0]  cmd_data;
  logic        cmd_ready;
  logic        resp_valid;
  logic [7:0]  resp_data;
  logic        id_mode;
  logic        ce_n;
  logic        oe_n;
  logic        we_n;
  logic [16:0] fl_addr;
  logic [7:0]  host_dq;
  logic        host_oe;
  logic        hv;
  logic [7:0]  dev_dq;
  logic        dev_oe;
  logic        clash;
  logic [7:0]  dq_wire;
  int          fail_count;
  int          checks;
  // resolved data pins seen by both parties
  assign dq_wire = host_oe ? host_dq : dev_dq;
  flash_cmd_host uut (.REF_CLK_IN(clk), .SRST_IN(rst), .CMD_VALID_IN(cmd_valid),
    .CMD_OP_IN(cmd_op), .CMD_ADDR_IN(cmd_addr), .CMD_DATA_IN(cmd_data),
    .CMD_READY_OUT(cmd_ready), .RESP_VALID_OUT(resp_valid), .RESP_DATA_OUT(resp_data),
    .ID_MODE_OUT(id_mode), .FLASH_CE_N_OUT(ce_n), .FLASH_OE_N_OUT(oe_n),
    .FLASH_WE_N_OUT(we_n), .FLASH_ADDR_OUT(fl_addr), .DATA_PINS_IN(dq_wire),
    .DATA_PINS_OUT(host_dq), .DATA_PINS_OE_OUT(host_oe), .ID_VOLTAGE_EN_OUT(hv));
  flash_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .PROT_MAP(PROT)) dev (
    .ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n), .addr_in(fl_addr), .dq_in(dq_wire),
    .host_oe_in(host_oe), .hv_in(hv), .dq_out(dev_dq), .dq_oe_out(dev_oe),
    .clash_out(clash));
  // 125 MHz clock
  always #4 clk = ~clk;
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // one command through the request port; bounded waits end the run on a hang
  task automatic run_op(input flash_host_pkg::op_t op, input logic [16:0] a,
                        input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    r = 'x;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    do begin
      @(posedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 50);
    if (cmd_ready !== 1'b1) begin
      fail_count++;
      $display("MISMATCH command accept expected ready seen busy");
      tally_and_finish();
    end
    cmd_valid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
      if (resp_valid === 1'b1) r = resp_data;
    end while (cmd_ready !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      fail_count++;
      $display("MISMATCH command completion expected ready seen busy");
      tally_and_finish();
    end
  endtask : run_op
  task automatic op_chk(input flash_host_pkg::op_t op, input logic [16:0] a,
                        input logic [7:0] exp, input string name);
    logic [7:0] r;
    run_op(op, a, 8'h00, r);
    check(name, r, exp);
  endtask : op_chk
  task automatic t_powerup;
    op_chk(flash_host_pkg::OP_READ, 17'h00123, 8'hFF, "erased low byte");
    op_chk(flash_host_pkg::OP_READ, 17'h1FFFF, 8'hFF, "erased top byte");
    $display("test powerup done");
  endtask : t_powerup
  task automatic t_program;
    logic [7:0] r;
    run_op(flash_host_pkg::OP_PROGRAM, 17'h1C005, 8'h3C, r);
    op_chk(flash_host_pkg::OP_READ, 17'h1C005, 8'h3C, "program top sector");
    run_op(flash_host_pkg::OP_PROGRAM, 17'h00040, 8'h5A, r);
    op_chk(flash_host_pkg::OP_READ, 17'h00040, 8'h5A, "program sector 0");
    // sector 2 is protected, so the byte must stay erased
    run_op(flash_host_pkg::OP_PROGRAM, 17'h08010, 8'h00, r);
    op_chk(flash_host_pkg::OP_READ, 17'h08010, 8'hFF, "protected program");
    $display("test program done");
  endtask : t_program
  task automatic t_hv_id;
    logic [7:0] r;
    check("id mode idle", {7'h00, id_mode}, 8'h00);
    run_op(flash_host_pkg::OP_ID_READ, 17'h1FFF0, 8'h00, r);
    check("maker code", r, MAKER);
    check("maker parity", {7'h00, ^r}, 8'h01);
    run_op(flash_host_pkg::OP_ID_READ, 17'h0AAA1, 8'h00, r);
    check("part code", r, PART);
    check("part parity", {7'h00, ^r}, 8'h01);
    // walk every sector for its protection bit
    for (int s = 0; s < 8; s++) begin
      op_chk(flash_host_pkg::OP_ID_READ, {s[2:0], 14'h0002}, {7'h00, PROT[s]}, "protect bit");
    end
    $display("test hv_id done");
  endtask : t_hv_id
  task automatic t_cmd_id;
    logic [7:0] r;
    run_op(flash_host_pkg::OP_ID_ENTER, 17'h00000, 8'h00, r);
    check("id mode set", {7'h00, id_mode}, 8'h01);
    op_chk(flash_host_pkg::OP_ID_READ, 17'h00000, MAKER, "cmd maker");
    op_chk(flash_host_pkg::OP_ID_READ, 17'h00001, PART, "cmd part");
    op_chk(flash_host_pkg::OP_ID_READ, 17'h14002, 8'h01, "cmd protect");
    // an array read still lands in the identifier space until reset
    op_chk(flash_host_pkg::OP_READ, 17'h1C005, PART, "id persists");
    run_op(flash_host_pkg::OP_RESET, 17'h00000, 8'h00, r);
    check("id mode clear", {7'h00, id_mode}, 8'h00);
    op_chk(flash_host_pkg::OP_READ, 17'h1C005, 8'h3C, "array after reset");
    op_chk(flash_host_pkg::OP_READ, 17'h00040, 8'h5A, "array stays");
    $display("test cmd_id done");
  endtask : t_cmd_id
  task automatic t_erase;
    logic [7:0] r;
    run_op(flash_host_pkg::OP_SECTOR_ERASE, 17'h1E777, 8'h00, r);
    op_chk(flash_host_pkg::OP_READ, 17'h1C005, 8'hFF, "sector erased");
    op_chk(flash_host_pkg::OP_READ, 17'h00040, 8'h5A, "other sector");
    run_op(flash_host_pkg::OP_CHIP_ERASE, 17'h00000, 8'h00, r);
    op_chk(flash_host_pkg::OP_READ, 17'h00040, 8'hFF, "chip erased");
    check("bus clash", {7'h00, clash}, 8'h00);
    $display("test erase done");
  endtask : t_erase
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = 3'h0;
    cmd_addr = 17'h00000;
    cmd_data = 8'h00;
    fail_count = 0;
    checks = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_powerup();
    t_program();
    t_hv_id();
    t_cmd_id();
    t_erase();
    tally_and_finish();
  end
endmodule : tb_top
